// ---- verification/dic_core_asserts.sv ----
// port checker of the interrupt control block
// assumes it is bound to dic_core with its default widths
`timescale 1ns/1ns
`default_nettype none
module dic_core_asserts
    import dic_pkg::*;
#(
    parameter int PC_W = DIC_PC_W
)
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire dic_instr_t instr_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic busy_o,
    input wire logic stack_push_o,
    input wire logic [PC_W-1:0] stack_top_data_o,
    input wire logic pc_load_o,
    input wire logic [PC_W-1:0] pc_vector_o,
    input wire logic irq_pending_flag_o,
    input wire logic irq_disable_bit_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    logic take;
    assign take = instr_i.done && irq_pending_flag_o && !irq_disable_bit_o
        && !instr_i.multiply && !instr_i.enable && !busy_o;
    ack_push_a: assert property (
        take |=> stack_push_o && stack_top_data_o == $past(pc_i))
        else $error("no push of return pc");
    push_load_a: assert property (
        stack_push_o |=> pc_load_o && busy_o && !stack_push_o)
        else $error("vector load missing after push");
    vector_two_a: assert property (
        pc_load_o |-> pc_vector_o == PC_W'(DIC_VECTOR))
        else $error("wrong vector");
    mult_hold_a: assert property (
        instr_i.done && instr_i.multiply |=> !stack_push_o)
        else $error("accepted after multiply");
    enable_clear_a: assert property (
        instr_i.done && instr_i.enable && !busy_o
        |=> !irq_disable_bit_o && !stack_push_o)
        else $error("enable handling wrong");
    mask_set_a: assert property (
        instr_i.done && instr_i.mask && !instr_i.enable && !busy_o
        |=> irq_disable_bit_o)
        else $error("mask did not disable");
    ack_disable_a: assert property (
        stack_push_o |-> irq_disable_bit_o)
        else $error("disable not set on entry");
    push_cause_a: assert property (
        $rose(stack_push_o) |-> $past(take))
        else $error("push without accepted request");
    cover property (take);
    cover property (instr_i.done && instr_i.enable && irq_pending_flag_o);
    cover property (instr_i.done && instr_i.multiply && irq_pending_flag_o);
    cover property (pc_load_o);
endmodule // dic_core_asserts
`default_nettype wire

// ---- verification/dic_periph_model.sv ----
// peripheral model: five request lines as short level pulses
// assumes fire_i pulses are one cycle and spaced apart
`timescale 1ns/1ns
`default_nettype none
module dic_periph_model
(
    input wire logic sys_clk_i,
    input wire logic coproc_mode_i,
    input wire logic slow_i,
    input wire logic [4:0] fire_i,
    output logic ext_pin_n_o,
    output logic [3:0] event_o
);
    logic [4:0] h1_q = '0;
    logic [4:0] h2_q = '0;
    logic [4:0] lvl_q = '0;
    // slow peripherals hold the line one cycle longer
    always_ff @(posedge sys_clk_i)
    begin
        h1_q <= fire_i;
        h2_q <= h1_q;
        lvl_q <= fire_i | h1_q | (h2_q & {5{slow_i}});
    end
    // in coprocessor mode no peripheral drives the line; fire_i[0] then
    // stands for port traffic on it, which must not count as a request
    assign ext_pin_n_o = ~lvl_q[0];
    assign event_o = lvl_q[4:1];
endmodule // dic_periph_model
`default_nettype wire

// ---- verification/tb_dic_core.sv ----
// self-checking bench of dic_core against a reference model
// assumes the checker and peripheral model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_dic_core
    import dic_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] addr = '0;
    logic [15:0] wdata = '0;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    dic_instr_t instr = '0;
    logic [11:0] pc = '0;
    logic [4:0] fire = '0;
    logic slow = 1'b0;
    logic cop = 1'b0;
    logic ext_n, busy, push, load, pend, dis;
    logic [3:0] ev;
    logic [11:0] stack_top, vec;
    logic [15:0] rdata;
    int err_total = 0;
    int compares = 0;
    int seed = 10;
    int ctrl_m = 0;
    bit pend_m = 0;
    bit dis_m = 1;
    initial
    begin
        forever #5 clk = ~clk;
    end
    dic_periph_model per_u (.sys_clk_i(clk), .coproc_mode_i(cop),
        .slow_i(slow), .fire_i(fire), .ext_pin_n_o(ext_n), .event_o(ev));
    dic_core dut_u (.sys_clk_i(clk), .reset_n_i(rst_n), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_write_i(wr_s), .reg_read_i(rd_s),
        .reg_rdata_o(rdata), .instr_i(instr), .pc_i(pc),
        .coproc_mode_i(cop), .coproc_ext_request_pin_n_i(ext_n),
        .recv_sync_event_i(ev[0]), .xmit_sync_event_i(ev[1]),
        .sync_pulse_event_i(ev[2]), .timer_sync_pulse_i(ev[3]),
        .busy_o(busy), .stack_push_o(push), .stack_top_data_o(stack_top),
        .pc_load_o(load), .pc_vector_o(vec), .irq_pending_flag_o(pend),
        .irq_disable_bit_o(dis));
    function automatic int rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string n, input logic [15:0] s,
        input logic [15:0] e);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("CHECK FAILED %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic test_done();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        // flags are write-one-to-clear, other bits plain
        if (a == 2'h0)
            ctrl_m = (d & 16'h02F0) | (ctrl_m & 16'h000F & ~d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, input int e, input string n);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(n, rdata, e[15:0]);
    endtask
    task automatic stat();
        rd(2'h1, {dis_m, pend_m}, "status");
        chk("pend pin", pend, pend_m);
        chk("dis pin", dis, dis_m);
    endtask
    task automatic fire_src(input int b);
        int f;
        f = (b > 3) ? 3 : b;
        @(posedge clk);
        fire <= 5'(1 << b);
        @(posedge clk);
        fire <= '0;
        repeat (6) @(posedge clk);
        // frame flag follows the selected source; ext ignored in coproc mode
        if (b == 3 ? ctrl_m[9] : b == 4 ? !ctrl_m[9] : !(b == 0 && cop))
            ctrl_m |= 1 << f;
        if (ctrl_m[f] && ctrl_m[f+4])
            pend_m = 1;
    endtask
    task automatic step(input logic m, input logic e, input logic k);
        logic [11:0] p;
        bit acc;
        p = 12'(rnd());
        acc = pend_m && !dis_m && !m && !e;
        @(posedge clk);
        instr <= '{1'b1, m, e, k};
        pc <= p;
        @(posedge clk);
        instr <= '0;
        #1 chk("push", push, acc);
        chk("busy", busy, acc);
        if (acc)
            chk("tos", stack_top, p);
        @(posedge clk);
        #1 chk("load", load, acc);
        chk("busy end", busy, acc);
        if (acc)
            chk("vector", vec, 12'h002);
        if (acc)
        begin
            pend_m = 0;
            dis_m = 1;
        end
        if (e)
            dis_m = 0;
        if (k)
            dis_m = 1;
        // a flag left set and enabled raises the request again on enable
        if (e && (ctrl_m[3:0] & ctrl_m[7:4]) != 0)
            pend_m = 1;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        chk("timeout", 16'h0001, 16'h0000);
        test_done();
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        rd(2'h0, 0, "ctrl reset");
        stat();
        rd(2'h2, 0, "unmapped");
        wr(2'h3, 16'hFFFF);
        wr(2'h0, 16'h02F0);
        rd(2'h0, ctrl_m, "ctrl");
        step(0, 1, 0);
        for (int b = 0; b < 4; b++)
        begin
            slow <= b[0];
            fire_src(b);
            rd(2'h0, ctrl_m, "flag set");
            wr(2'h0, 16'h02F0);
            rd(2'h0, ctrl_m, "flag kept");
            stat();
            step(1, 0, 0);
            step(0, 0, 0);
            stat();
            wr(2'h0, 16'(16'h02F0 | (1 << b)));
            rd(2'h0, ctrl_m, "flag clear");
            step(0, 1, 0);
        end
        step(0, 0, 1);
        stat();
        fire_src(0);
        step(0, 0, 0);
        stat();
        step(0, 1, 0);
        step(0, 0, 0);
        step(0, 1, 0);
        stat();
        step(0, 0, 0);
        wr(2'h0, 16'h02F1);
        step(0, 1, 0);
        wr(2'h0, 16'h0000);
        fire_src(4);
        rd(2'h0, ctrl_m, "timer flag");
        stat();
        wr(2'h0, 16'h0010);
        cop <= 1'b1;
        fire_src(0);
        rd(2'h0, ctrl_m, "coproc flag");
        stat();
        cop <= 1'b0;
        test_done();
    end
endmodule // tb_dic_core
bind dic_core dic_core_asserts #(.PC_W(PC_W)) chk_u (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .instr_i(instr_i),
    .pc_i(pc_i), .busy_o(busy_o), .stack_push_o(stack_push_o),
    .stack_top_data_o(stack_top_data_o), .pc_load_o(pc_load_o),
    .pc_vector_o(pc_vector_o), .irq_pending_flag_o(irq_pending_flag_o),
    .irq_disable_bit_o(irq_disable_bit_o));
`default_nettype wire

// ---- verilog/dic_core.sv ----
// interrupt control of the signal processor core: flags, masks, master
// pending flag, disable bit and the acknowledge sequence (push, vector)
// assumes the core pulses instr_i.done at each instruction boundary and
// holds off fetching while busy_o is high
`timescale 1ns/1ns
`default_nettype none
module dic_core
    import dic_pkg::*;
#(
    parameter bit SERIAL_VARIANT = 1'b1,
    parameter int PC_W = DIC_PC_W
)
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [DIC_ADDR_W-1:0] reg_addr_i,
    input wire logic [DIC_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [DIC_DATA_W-1:0] reg_rdata_o,
    // core side
    input wire dic_instr_t instr_i,
    input wire logic [PC_W-1:0] pc_i,
    input wire logic coproc_mode_i,
    // request sources
    input wire logic coproc_ext_request_pin_n_i,
    input wire logic recv_sync_event_i,
    input wire logic xmit_sync_event_i,
    input wire logic sync_pulse_event_i,
    input wire logic timer_sync_pulse_i,
    // acknowledge outputs
    output logic busy_o,
    output logic stack_push_o,
    output logic [PC_W-1:0] stack_top_data_o,
    output logic pc_load_o,
    output logic [PC_W-1:0] pc_vector_o,
    output logic irq_pending_flag_o,
    output logic irq_disable_bit_o
);
    logic [DIC_NSRC-1:0] src_level, src_rise;
    logic [DIC_NSRC-1:0] flag_q, flag_d;
    logic [DIC_NSRC-1:0] mask_q, mask_d;
    logic tsel_q, tsel_d;
    logic pend_q, pend_d;
    logic dis_q, dis_d;
    dic_state_t st_q, st_d;
    logic push_q, push_d;
    logic load_q, load_d;
    logic [PC_W-1:0] ret_q, ret_d;
    logic [DIC_DATA_W-1:0] rdata_q, rdata_d;
    logic merged_q, merged_d;
    logic ctrl_wr, req_evt, accept;
    logic busy_q, busy_d;
    logic [PC_W-1:0] vec_q;

    // external request ignored in coprocessor mode: pin belongs to the port
    always_comb
    begin
        src_level = '0;
        src_level[DIC_SRC_EXT] = ~coproc_ext_request_pin_n_i
            & ~coproc_mode_i;
        src_level[DIC_SRC_RECV] = recv_sync_event_i;
        src_level[DIC_SRC_XMIT] = xmit_sync_event_i;
        // framing pulse from internal timer when select is 0
        src_level[DIC_SRC_FRAME] = tsel_q ? sync_pulse_event_i
            : timer_sync_pulse_i;
    end

    dic_sync_edge #(
        .WIDTH(DIC_NSRC)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(reset_n_i),
        .level_i(src_level),
        .rise_o(src_rise)
    );

    assign ctrl_wr = reg_write_i && (reg_addr_i == DIC_CTRL_OFS);

    // flags and masks; a set in the clearing cycle wins
    always_comb
    begin
        flag_d = flag_q;
        mask_d = mask_q;
        tsel_d = tsel_q;
        if (ctrl_wr)
        begin
            flag_d = flag_q
                & ~reg_wdata_i[DIC_FLAG_LSB +: DIC_NSRC];
            mask_d = reg_wdata_i[DIC_MASK_LSB +: DIC_NSRC];
            tsel_d = reg_wdata_i[DIC_TSEL_BIT];
        end
        flag_d = flag_d | src_rise;
    end

    // merged master request: equal priority, no ordering among sources
    always_comb
    begin
        merged_d = |(flag_q & mask_q);
        if (SERIAL_VARIANT)
        begin
            // rising merge, or a still-set source seen when enabling again
            req_evt = (merged_d & ~merged_q)
                | (merged_d & instr_i.done & instr_i.enable);
        end
        else
        begin
            req_evt = src_rise[DIC_SRC_EXT];
        end
    end

    // boundary acceptance; not after multiply nor right after enable
    assign accept = (st_q == DIC_IDLE) && instr_i.done && pend_q
        && !dis_q
        && !instr_i.multiply
        && !instr_i.enable;

    always_comb
    begin
        pend_d = pend_q;
        dis_d = dis_q;
        st_d = st_q;
        push_d = 1'b0;
        load_d = 1'b0;
        ret_d = ret_q;
        if (instr_i.done && instr_i.enable && st_q == DIC_IDLE)
        begin
            dis_d = 1'b0;
        end
        if (instr_i.done && instr_i.mask && st_q == DIC_IDLE)
        begin
            dis_d = 1'b1;
        end
        case (st_q)
            DIC_IDLE:
            begin
                if (accept)
                begin
                    pend_d = 1'b0;
                    dis_d = 1'b1;
                    ret_d = pc_i;
                    push_d = 1'b1;
                    st_d = DIC_PUSH;
                end
            end
            DIC_PUSH:
            begin
                load_d = 1'b1;
                st_d = DIC_VECT;
            end
            DIC_VECT:
            begin
                st_d = DIC_IDLE;
            end
            default:
            begin
                st_d = DIC_IDLE;
            end
        endcase
        // a request in the acknowledge cycle stays pending
        if (req_evt)
        begin
            pend_d = 1'b1;
        end
        // busy is registered from the next state, so it matches the sequence state, like the pulses
        busy_d = (st_d != DIC_IDLE);
    end

    // read data valid in the cycle after the strobe only
    always_comb
    begin
        rdata_d = '0;
        if (reg_read_i)
        begin
            case (reg_addr_i)
                DIC_CTRL_OFS:
                begin
                    rdata_d[DIC_FLAG_LSB +: DIC_NSRC] = flag_q;
                    rdata_d[DIC_MASK_LSB +: DIC_NSRC] = mask_q;
                    rdata_d[DIC_TSEL_BIT] = tsel_q;
                end
                DIC_STAT_OFS:
                begin
                    rdata_d[DIC_STAT_PEND_BIT] = pend_q;
                    rdata_d[DIC_STAT_DIS_BIT] = dis_q;
                    rdata_d[DIC_STAT_BUSY_BIT] = (st_q != DIC_IDLE);
                end
                default:
                begin
                    rdata_d = '0;
                end
            endcase
        end
    end

    // flags, masks and frame source select
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            flag_q <= DIC_FLAG_RST;
            mask_q <= DIC_MASK_RST;
            tsel_q <= DIC_TSEL_RST;
        end
        else
        begin
            flag_q <= flag_d;
            mask_q <= mask_d;
            tsel_q <= tsel_d;
        end
    end

    // merged request history for the rise detector
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            merged_q <= 1'b0;
        end
        else
        begin
            merged_q <= merged_d;
        end
    end

    // pending, disable and the acknowledge sequence
    // disable comes out of reset set: nothing is taken before enable
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pend_q <= 1'b0;
            dis_q <= DIC_DIS_RST;
            st_q <= DIC_IDLE;
            push_q <= 1'b0;
            load_q <= 1'b0;
            ret_q <= '0;
            busy_q <= 1'b0;
        end
        else
        begin
            pend_q <= pend_d;
            dis_q <= dis_d;
            st_q <= st_d;
            push_q <= push_d;
            load_q <= load_d;
            ret_q <= ret_d;
            busy_q <= busy_d;
        end
    end

    // read data register, cleared when no read is under way
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    // vector kept in a flop so that every output leaves a register
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            vec_q <= PC_W'(DIC_VECTOR);
        end
        else
        begin
            vec_q <= PC_W'(DIC_VECTOR);
        end
    end

    assign busy_o = busy_q;
    assign stack_push_o = push_q;
    assign stack_top_data_o = ret_q;
    assign pc_load_o = load_q;
    assign pc_vector_o = vec_q;
    assign irq_pending_flag_o = pend_q;
    assign irq_disable_bit_o = dis_q;
    assign reg_rdata_o = rdata_q;
endmodule // dic_core
`default_nettype wire

// ---- verilog/dic_pkg.sv ----
// constants and carrier types of the interrupt control block
// assumes a core that reports each finished instruction with its class
package dic_pkg;
    localparam int DIC_ADDR_W = 2;
    localparam int DIC_DATA_W = 16;
    localparam int DIC_PC_W = 12;
    localparam int DIC_NSRC = 4;
    localparam logic [1:0] DIC_CTRL_OFS = 2'h0;
    localparam logic [1:0] DIC_STAT_OFS = 2'h1;
    localparam int DIC_FLAG_LSB = 0;
    localparam int DIC_MASK_LSB = 4;
    localparam int DIC_TSEL_BIT = 9;
    localparam int DIC_STAT_PEND_BIT = 0;
    localparam int DIC_STAT_DIS_BIT = 1;
    localparam int DIC_STAT_BUSY_BIT = 2;
    localparam logic [3:0] DIC_FLAG_RST = 4'h0;
    localparam logic [3:0] DIC_MASK_RST = 4'h0;
    localparam logic DIC_TSEL_RST = 1'b0;
    localparam logic DIC_DIS_RST = 1'b1;
    localparam logic [11:0] DIC_VECTOR = 12'h002;
    // source index order within flag and mask fields
    localparam int DIC_SRC_EXT = 0;
    localparam int DIC_SRC_RECV = 1;
    localparam int DIC_SRC_XMIT = 2;
    localparam int DIC_SRC_FRAME = 3;

    typedef struct packed {
        logic done;
        logic multiply;
        logic enable;
        logic mask;
    } dic_instr_t;

    typedef enum logic [1:0] {
        DIC_IDLE,
        DIC_PUSH,
        DIC_VECT
    } dic_state_t;
endpackage

// ---- verilog/dic_sync_edge.sv ----
// two-stage synchronizer with rising-edge pulse, one per source bit
// assumes active-high inputs; edge taken after the second stage only
`timescale 1ns/1ns
`default_nettype none
module dic_sync_edge
    import dic_pkg::*;
#(
    parameter int WIDTH = 4
)
(
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] level_i,
    output logic [WIDTH-1:0] rise_o
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q;
    logic [WIDTH-1:0] s1_d, s2_d, s3_d;

    always_comb
    begin
        s1_d = level_i;
        s2_d = s1_q;
        s3_d = s2_q;
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end
        else
        begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
        end
    end

    assign rise_o = s2_q & ~s3_q;
endmodule // dic_sync_edge
`default_nettype wire
